// *** rtl/plcsr_pkg.sv ***
// Purpose: constants for the pulse loop control and status register group
// Assumes: byte-wide registers on a 16-bit register address
// Notes: unlisted bit positions are masked to zero on read and write
package plcsr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [15:0] OFS_CONTROL = 16'h5320;
	localparam logic [15:0] OFS_HIST = 16'h5321;
	localparam logic [15:0] OFS_EVENTS = 16'h5322;
	localparam logic [15:0] OFS_LOSS = 16'h5323;
	localparam logic [15:0] OFS_HOLD = 16'h5324;

	// control register fields
	localparam int CTL_PULSE_EN_BIT = 0;
	localparam int CTL_ACQ_SEL_BIT = 4;
	localparam int CTL_SKIP_WAIT_BIT = 6;
	localparam logic [7:0] CTL_MASK = 8'h51;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// holdover history register
	localparam int HIST_OK_BIT = 0;

	// event register fields
	localparam int EV_OVERFLOW_BIT = 7;
	localparam int EV_UNDERFLOW_BIT = 6;
	localparam int EV_FAST_EXIT_BIT = 4;
	localparam int EV_PHASE_PULL_BIT = 3;
	localparam int EV_PHASE_RANGE_BIT = 2;
	localparam int EV_FREQ_PULL_BIT = 1;
	localparam int EV_FREQ_RANGE_BIT = 0;
	localparam logic [7:0] EV_MASK = 8'hDF;

	// input loss register fields
	localparam int LOSS_LIVE_BIT = 0;
	localparam int LOSS_STICKY_BIT = 4;
	localparam logic [7:0] LOSS_STICKY_MASK = 8'h10;

	// holdover, lock and tracking register fields
	localparam int HOLD_STICKY_BIT = 7;
	localparam int UNLOCK_STICKY_BIT = 5;
	localparam int NOTRACK_STICKY_BIT = 4;
	localparam int HOLD_LIVE_BIT = 3;
	localparam int UNLOCK_LIVE_BIT = 1;
	localparam int NOTRACK_LIVE_BIT = 0;
	localparam logic [7:0] HOLD_STICKY_MASK = 8'hB0;

	localparam logic [7:0] STICKY_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// acquisition sequencer, gray coded along the usual path
	typedef enum logic [1:0] {
		PLCSR_IDLE = 2'b00,
		PLCSR_WAIT_LOCK = 2'b01,
		PLCSR_ACQUIRE = 2'b11,
		PLCSR_RUN = 2'b10
	} plcsr_state_t;
endpackage

// *** rtl/plcsr_sticky_bank.sv ***
// Purpose: byte of sticky event flags, cleared by writing zero
// Assumes: set inputs are synchronous levels or pulses
// Notes: a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module plcsr_sticky_bank
	import plcsr_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hFF
)
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// register side
	plcsr_sticky_if.bank sb
);
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] clear_mask;

	// writing 1 leaves a flag alone, writing 0 clears it
	always_comb
	begin
		clear_mask = sb.wr ? ~sb.wdata : ZERO_BYTE; // [RULE7] [RULE16]
		flags_next = ((flags_reg & ~clear_mask) | sb.set) & MASK; // [RULE16] [RULE17]
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			flags_reg <= STICKY_RESET;
		else if (ce_in)
			flags_reg <= flags_next;
	end

	assign sb.flags = flags_reg;
endmodule
`default_nettype wire

// *** rtl/plcsr_sticky_if.sv ***
// Purpose: carrier between the register file and a sticky flag bank
// Assumes: one byte of flags per bank
// Notes: flags is the only signal driven by the bank
`timescale 1ns/1ps
`default_nettype none
interface plcsr_sticky_if;
	logic [7:0] set;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] flags;

	modport bank (input set, input wr, input wdata, output flags);
	modport user (output set, output wr, output wdata, input flags);
endinterface
`default_nettype wire

// *** rtl/plcsr_top.sv ***
// Purpose: control and status registers of the one pulse per second loop
// Assumes: register port and status inputs synchronous to clk_sys_in
// Notes: read data appears one cycle after the read strobe
//  a sticky set in the cycle of its clearing write wins, so no event is lost
//  ce_in low freezes every register, sticky banks and read pipe included
//  a read in the same cycle as a write returns the value before the write
//  the acquisition mode is latched once per enable, later select writes wait
//  writes to the history register and to unmapped offsets are dropped
//
// Summary of operation
// [RULE1] control bit 0 enables pulse mode
// [RULE2] bit 6 low: wait for reference lock
// [RULE3] bit 4 picks acquisition mode A/B
// [RULE4] history bit reads 1 once data enough
// [RULE5] event bit 7 sticks on accumulator overflow
// [RULE6] event bit 6 sticks on accumulator underflow
// [RULE7] sticky flags clear only by writing 0
// [RULE8] bits 4,3,1 stick on pull errors
// [RULE9] bits 2,0 stick on initial range errors
// [RULE10] loss bit 0 shows live input loss
// [RULE11] loss bit 4 is sticky input loss
// [RULE12] status bit 3 shows live holdover
// [RULE13] bits 1,0 show unlocked and not tracking
// [RULE14] status bit 7 is sticky holdover
// [RULE15] bits 5,4 sticky unlocked, not tracking
// [RULE16] sticky holds; writing 1 changes nothing
// [RULE17] read-only and unlisted bits ignore writes
`timescale 1ns/1ps
`default_nettype none
module plcsr_top
	import plcsr_pkg::*;
(
	// clock, reset and enable
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// register port
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	// live loop status
	input wire logic holdover_history_ok_in,
	input wire logic holdover_in,
	input wire logic loop_unlocked_in,
	input wire logic loop_not_tracking_in,
	input wire logic pulse_input_loss_in,
	input wire logic ref_loop_locked_in,
	// loop events
	input wire logic osc_accum_overflow_in,
	input wire logic osc_accum_underflow_in,
	input wire logic fast_lock_exit_error_in,
	input wire logic phase_pull_error_in,
	input wire logic phase_range_error_in,
	input wire logic freq_pull_error_in,
	input wire logic freq_range_error_in,
	// loop control
	output logic pulse_mode_enable_out,
	output logic initial_acquisition_select_out,
	output logic acquisition_start_out,
	output logic acquisition_active_out
);
	plcsr_sticky_if ev_if ();
	plcsr_sticky_if loss_if ();
	plcsr_sticky_if hold_if ();

	logic [7:0] control_reg;
	logic [7:0] control_next;
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	logic rd_valid_reg;
	logic rd_valid_next;
	plcsr_state_t state_reg;
	plcsr_state_t state_next;
	logic start_reg;
	logic start_next;
	logic mode_reg;
	logic mode_next;
	logic hit_control;
	logic hit_events;
	logic hit_loss;
	logic hit_hold;
	logic hit_hist;
	logic wr_control;
	logic wr_events;
	logic wr_loss;
	logic wr_hold;
	logic lock_ok;
	logic disable_pending;

	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	// write strobe aimed at one register offset
	function automatic logic wr_hit(input logic wr, input logic [15:0] a,
		input logic [15:0] ofs);
		wr_hit = wr & addr_hit(a, ofs);
	endfunction

	// address decode shared by reads and writes; the history offset has no write
	always_comb
	begin
		hit_control = addr_hit(addr_in, OFS_CONTROL);
		hit_hist = addr_hit(addr_in, OFS_HIST);
		hit_events = addr_hit(addr_in, OFS_EVENTS);
		hit_loss = addr_hit(addr_in, OFS_LOSS);
		hit_hold = addr_hit(addr_in, OFS_HOLD);
		wr_control = wr_hit(wr_in, addr_in, OFS_CONTROL);
		wr_events = wr_hit(wr_in, addr_in, OFS_EVENTS); // [RULE7]
		wr_loss = wr_hit(wr_in, addr_in, OFS_LOSS); // [RULE7]
		wr_hold = wr_hit(wr_in, addr_in, OFS_HOLD); // [RULE7]
	end

	// loop events into the event bank; all seven flags share one byte
	always_comb
	begin
		ev_if.set = ZERO_BYTE;
		ev_if.set[EV_OVERFLOW_BIT] = osc_accum_overflow_in; // [RULE5]
		ev_if.set[EV_UNDERFLOW_BIT] = osc_accum_underflow_in; // [RULE6]
		ev_if.set[EV_FAST_EXIT_BIT] = fast_lock_exit_error_in; // [RULE8]
		ev_if.set[EV_PHASE_PULL_BIT] = phase_pull_error_in; // [RULE8]
		ev_if.set[EV_FREQ_PULL_BIT] = freq_pull_error_in; // [RULE8]
		ev_if.set[EV_PHASE_RANGE_BIT] = phase_range_error_in; // [RULE9]
		ev_if.set[EV_FREQ_RANGE_BIT] = freq_range_error_in; // [RULE9]
		ev_if.wr = wr_events; // [RULE7]
		ev_if.wdata = wr_data_in;
	end

	// input loss into its bank; the live bit is read straight from the pin
	always_comb
	begin
		loss_if.set = ZERO_BYTE;
		loss_if.set[LOSS_STICKY_BIT] = pulse_input_loss_in; // [RULE11]
		loss_if.wr = wr_loss; // [RULE7]
		loss_if.wdata = wr_data_in;
	end

	// holdover, lock and tracking into their bank
	always_comb
	begin
		hold_if.set = ZERO_BYTE;
		hold_if.set[HOLD_STICKY_BIT] = holdover_in; // [RULE14]
		hold_if.set[UNLOCK_STICKY_BIT] = loop_unlocked_in; // [RULE15]
		hold_if.set[NOTRACK_STICKY_BIT] = loop_not_tracking_in; // [RULE15]
		hold_if.wr = wr_hold; // [RULE7]
		hold_if.wdata = wr_data_in;
	end

	plcsr_sticky_bank #(
		.MASK(EV_MASK)
	) u_events (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.sb(ev_if.bank)
	);

	plcsr_sticky_bank #(
		.MASK(LOSS_STICKY_MASK)
	) u_loss (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.sb(loss_if.bank)
	);

	plcsr_sticky_bank #(
		.MASK(HOLD_STICKY_MASK)
	) u_hold (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.sb(hold_if.bank)
	);

	// control register; only listed bits are stored
	always_comb
	begin
		control_next = control_reg;
		if (wr_control)
			control_next = wr_data_in & CTL_MASK; // [RULE17]
	end

	// read mux; live bits sampled at the read, others read as zero
	// unmapped offsets keep the zero default but still answer
	always_comb
	begin
		rd_valid_next = rd_in;
		rd_data_next = ZERO_BYTE;
		if (rd_in)
		begin
			if (hit_control)
				rd_data_next = control_reg;
			else if (hit_hist)
				rd_data_next[HIST_OK_BIT] = holdover_history_ok_in; // [RULE4]
			else if (hit_events)
				rd_data_next = ev_if.flags;
			else if (hit_loss)
			begin
				rd_data_next = loss_if.flags;
				rd_data_next[LOSS_LIVE_BIT] = pulse_input_loss_in; // [RULE10]
			end
			else if (hit_hold)
			begin
				rd_data_next = hold_if.flags;
				rd_data_next[HOLD_LIVE_BIT] = holdover_in; // [RULE12]
				rd_data_next[UNLOCK_LIVE_BIT] = loop_unlocked_in; // [RULE13]
				rd_data_next[NOTRACK_LIVE_BIT] = loop_not_tracking_in; // [RULE13]
			end
		end
	end

	// lock gate and a disable arriving in the same cycle; without the
	// second term a start pulse could leave after the enable was cleared
	always_comb
	begin
		lock_ok = control_reg[CTL_SKIP_WAIT_BIT] || ref_loop_locked_in; // [RULE2]
		disable_pending = !control_next[CTL_PULSE_EN_BIT]; // [RULE1]
	end

	// acquisition sequencer; mode is latched on entry so later writes
	// to the select bit do not disturb an acquisition already under way
	always_comb
	begin
		state_next = state_reg;
		start_next = 1'b0;
		mode_next = mode_reg;
		if (!control_reg[CTL_PULSE_EN_BIT])
			state_next = PLCSR_IDLE; // [RULE1]
		else
		begin
			unique case (state_reg)
				PLCSR_IDLE:
				begin
					mode_next = control_reg[CTL_ACQ_SEL_BIT]; // [RULE3]
					state_next = PLCSR_WAIT_LOCK; // [RULE1]
				end
				PLCSR_WAIT_LOCK:
				begin
					// stall until the reference loop locks or the wait is skipped
					if (lock_ok && !disable_pending) // [RULE2]
					begin
						state_next = PLCSR_ACQUIRE;
						start_next = 1'b1;
					end
				end
				PLCSR_ACQUIRE:
					state_next = PLCSR_RUN;
				PLCSR_RUN:
					state_next = PLCSR_RUN;
			endcase
		end
	end

	// control register
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			control_reg <= CTL_RESET;
		else if (ce_in)
			control_reg <= control_next;
	end

	// read pipe; data returns to zero when no read is answered
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rd_data_reg <= ZERO_BYTE;
			rd_valid_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	// sequencer state, start pulse and latched mode
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg <= PLCSR_IDLE;
			start_reg <= 1'b0;
			mode_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			state_reg <= state_next;
			start_reg <= start_next;
			mode_reg <= mode_next;
		end
	end

	// outputs straight from flip-flops
	assign rd_data_out = rd_data_reg;
	assign rd_valid_out = rd_valid_reg;
	assign pulse_mode_enable_out = control_reg[CTL_PULSE_EN_BIT]; // [RULE1]
	assign initial_acquisition_select_out = mode_reg; // [RULE3]
	assign acquisition_start_out = start_reg;
	assign acquisition_active_out = state_reg[1];
endmodule
`default_nettype wire

// *** tb/plcsr_top_props.sv ***
// Purpose: port assertions for the pulse loop registers
// Assumes: one clock, async active high reset
// Notes: bound to plcsr_top after the module
`timescale 1ns/1ps
`default_nettype none
module plcsr_top_props
	import plcsr_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// register port
	input wire logic ce_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] rd_data_out,
	input wire logic rd_valid_out,
	// status and events
	input wire logic holdover_in,
	input wire logic loop_unlocked_in,
	input wire logic loop_not_tracking_in,
	input wire logic pulse_input_loss_in,
	input wire logic osc_accum_overflow_in,
	input wire logic osc_accum_underflow_in,
	// loop control
	input wire logic pulse_mode_enable_out,
	input wire logic acquisition_start_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	// control writes and the sequencer gate
	en_set_a: assert property (ce_in && wr_in && addr_in == OFS_CONTROL
		&& wr_data_in[0] |=> pulse_mode_enable_out) else $error("enable not set");
	start_gate_a: assert property (acquisition_start_out |-> pulse_mode_enable_out)
		else $error("start while disabled");
	// sticky sets seen by a following read; set wins over a clear
	ovf_stick_a: assert property (ce_in && osc_accum_overflow_in ##1 ce_in && rd_in
		&& addr_in == OFS_EVENTS |=> rd_data_out[7]) else $error("overflow lost");
	udf_stick_a: assert property (ce_in && osc_accum_underflow_in ##1 ce_in && rd_in
		&& addr_in == OFS_EVENTS |=> rd_data_out[6]) else $error("underflow lost");
	// live bits are sampled in the read cycle
	loss_live_a: assert property (ce_in && rd_in && addr_in == OFS_LOSS
		|=> rd_data_out[0] == $past(pulse_input_loss_in)) else $error("loss bit");
	hold_live_a: assert property (ce_in && rd_in && addr_in == OFS_HOLD
		|=> rd_data_out[3] == $past(holdover_in)) else $error("hold bit");
	lock_live_a: assert property (ce_in && rd_in && addr_in == OFS_HOLD
		|=> rd_data_out[1:0] == {$past(loop_unlocked_in), $past(loop_not_tracking_in)})
		else $error("lock bits");
	unmapped_zero_a: assert property (ce_in && rd_in && (addr_in > OFS_HOLD)
		|=> rd_valid_out && rd_data_out == 8'h00) else $error("unmapped read");
endmodule
bind plcsr_top plcsr_top_props i_plcsr_top_props (.clk_sys_in, .rst_in, .ce_in, .wr_in,
	.rd_in, .addr_in, .wr_data_in, .rd_data_out, .rd_valid_out, .holdover_in, .loop_unlocked_in,
	.loop_not_tracking_in, .pulse_input_loss_in, .osc_accum_overflow_in,
	.osc_accum_underflow_in, .pulse_mode_enable_out, .acquisition_start_out);
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the pulse loop registers
// Assumes: read data one cycle after the strobe
// Notes: inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb
	import plcsr_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic locked = 1'b0;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] wr_data_in = 8'h00;
	logic [7:0] ev = 8'h00;
	logic [4:0] st = 5'h00; // history, hold, unlock, no track, loss
	logic [7:0] rd_data_out;
	logic rd_valid_out, en_out, sel_out, start_out, act_out;
	int failures = 0;
	int n_checks = 0;

	// 250 MHz system clock
	always #2 clk_sys_in = ~clk_sys_in;

	plcsr_top i_plcsr_top (.clk_sys_in, .rst_in, .ce_in, .wr_in, .rd_in, .addr_in,
		.wr_data_in, .rd_data_out, .rd_valid_out, .holdover_history_ok_in(st[4]),
		.holdover_in(st[3]), .loop_unlocked_in(st[2]), .loop_not_tracking_in(st[1]),
		.pulse_input_loss_in(st[0]), .ref_loop_locked_in(locked),
		.osc_accum_overflow_in(ev[7]), .osc_accum_underflow_in(ev[6]),
		.fast_lock_exit_error_in(ev[4]), .phase_pull_error_in(ev[3]),
		.phase_range_error_in(ev[2]), .freq_pull_error_in(ev[1]),
		.freq_range_error_in(ev[0]), .pulse_mode_enable_out(en_out),
		.initial_acquisition_select_out(sel_out), .acquisition_start_out(start_out),
		.acquisition_active_out(act_out));

	// compare, count and report
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one-cycle strobes; read data judged mid-cycle after the answer edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		chk("rd_valid", {7'h00, rd_valid_out}, 8'h01);
		chk("rd_data", rd_data_out, exp);
	endtask

	// bounded wait sampled mid-cycle, clear of the launching edge
	task automatic wait_start();
		for (int k = 0; k < 20 && start_out !== 1'b1; k++)
			@(negedge clk_sys_in);
		chk("start", {7'h00, start_out}, 8'h01);
		chk("active", {7'h00, act_out}, 8'h01);
		if (start_out !== 1'b1)
			conclude();
	endtask

	task automatic t_reset();
		rd(OFS_CONTROL, 8'h00);
		rd(OFS_EVENTS, 8'h00);
		rd(OFS_LOSS, 8'h00);
		rd(OFS_HOLD, 8'h00);
		rd(16'h5325, 8'h00);
		$display("reset values done");
	endtask

	// lock wait held off until the reference locks, then skipped by bit 6
	task automatic t_control();
		wr(OFS_CONTROL, 8'hAE);
		rd(OFS_CONTROL, 8'h00);
		wr(OFS_CONTROL, 8'h11);
		repeat (8) @(posedge clk_sys_in);
		chk("enable", {7'h00, en_out}, 8'h01);
		chk("select", {7'h00, sel_out}, 8'h01);
		chk("active", {7'h00, act_out}, 8'h00);
		locked <= 1'b1;
		wait_start();
		wr(OFS_CONTROL, 8'h00);
		locked <= 1'b0;
		wr(OFS_CONTROL, 8'h41);
		wait_start();
		rd(OFS_CONTROL, 8'h41);
		chk("select", {7'h00, sel_out}, 8'h00);
		@(posedge clk_sys_in);
		ce_in <= 1'b0;
		wr(OFS_CONTROL, 8'h00);
		ce_in <= 1'b1;
		chk("frozen", {7'h00, en_out}, 8'h01);
		$display("control done");
	endtask

	// all events held across a read, then cleared one bit at a time
	task automatic t_events();
		logic [7:0] exp;
		exp = EV_MASK;
		@(posedge clk_sys_in);
		ev <= 8'hFF;
		rd(OFS_EVENTS, exp);
		@(posedge clk_sys_in);
		ev <= 8'h00;
		wr(OFS_EVENTS, 8'hFF);
		rd(OFS_EVENTS, exp);
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_EVENTS, ~(8'h01 << i));
			exp = exp & ~(8'h01 << i);
			rd(OFS_EVENTS, exp);
		end
		$display("event flags done");
	endtask

	// live status, then sticky copies after the live state drops
	task automatic t_status();
		@(posedge clk_sys_in);
		st <= 5'h0F;
		rd(OFS_LOSS, 8'h11);
		rd(OFS_HOLD, 8'hBB);
		rd(OFS_HIST, 8'h00);
		@(posedge clk_sys_in);
		st <= 5'h10;
		wr(OFS_HIST, 8'hFE);
		rd(OFS_HIST, 8'h01);
		rd(OFS_LOSS, 8'h10);
		rd(OFS_HOLD, 8'hB0);
		wr(OFS_LOSS, 8'hEF);
		wr(OFS_HOLD, 8'h00);
		rd(OFS_LOSS, 8'h00);
		rd(OFS_HOLD, 8'h00);
		$display("status done");
	endtask

	// reset again mid-run with pulse mode on and event flags just set
	task automatic t_midreset();
		@(posedge clk_sys_in);
		ev <= 8'hFF;
		@(posedge clk_sys_in);
		ev <= 8'h00;
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		chk("enable", {7'h00, en_out}, 8'h00);
		chk("active", {7'h00, act_out}, 8'h00);
		rd(OFS_CONTROL, 8'h00);
		rd(OFS_EVENTS, 8'h00);
		$display("mid-run reset done");
	endtask

	// reset for two cycles, then every scenario in turn
	initial
	begin
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		t_reset();
		t_control();
		t_events();
		t_status();
		t_midreset();
		conclude();
	end
endmodule
`default_nettype wire
